/* hdl/pac_pkg.sv */
// Constants, register map and carrier types of the prescaled 16-bit counter
// What this block does
// [RULE1] Counter input is divided by one, two, four or eight before counting.
// [RULE2] Prescale-select field in the control register picks the division ratio.
// [RULE3] The prescale counter has no address; software cannot read or write it.
// [RULE4] A write to either count byte clears the prescale counter.
// [RULE5] Bypass bit set: external clock skips resync stage, counts asynchronously.
// [RULE6] Asynchronous external counting continues while the processor sleeps.
// [RULE7] Overflow during asynchronous sleep counting can raise a waking interrupt.
// [RULE8] Switching synchronous to asynchronous may lose one increment.
// [RULE9] Switching asynchronous to synchronous may add one increment.
// [RULE10] Reading either count byte always returns a settled, valid byte.
// [RULE11] Software reading two bytes must guard against overflow between reads.
// [RULE12] Software should stop the counter before writing new count values.
// [RULE13] A write colliding with an increment may leave an unpredictable pair.
// [RULE14] Wrap from all ones sets a sticky overflow flag until software clears.
`default_nettype none
package pac_pkg;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] PAC_OFS_CTRL   = 8'h00;
    localparam logic [7:0] PAC_OFS_CNT_LO = 8'h04;
    localparam logic [7:0] PAC_OFS_CNT_HI = 8'h08;
    localparam logic [7:0] PAC_OFS_STAT   = 8'h0c;
    localparam logic [7:0] PAC_OFS_MASK   = 8'h10;

    // ************************************************************
    // Control field positions and reset values
    // ************************************************************
    localparam int         PAC_BIT_ON      = 0;
    localparam int         PAC_BIT_BYPASS  = 1;
    localparam int         PAC_BIT_EXTSEL  = 2;
    localparam int         PAC_PSC_LSB     = 4;
    localparam int         PAC_BIT_OVF     = 0;
    localparam logic [7:0] PAC_CTRL_RESET  = 8'h00;
    localparam logic [7:0] PAC_COUNT_RESET = 8'h00;
    localparam logic [0:0] PAC_FLAG_RESET  = 1'h0;
    localparam logic [0:0] PAC_MASK_RESET  = 1'h0;
    localparam logic [2:0] PAC_PSC_RESET   = 3'h0;

    // Prescale counter width serves ratios up to eight
    localparam int         PAC_PSC_W       = 3;

    typedef enum logic [1:0] {
        PAC_DIV1,
        PAC_DIV2,
        PAC_DIV4,
        PAC_DIV8
    } pac_div_type;

    typedef struct packed {
        pac_div_type prescaleSel;
        logic        extClkSel;
        logic        syncBypass;
        logic        on;
    } pac_ctrl_type;

    typedef struct packed {
        logic [7:0] countHigh;
        logic [7:0] countLow;
    } pac_count_type;

    typedef enum logic [2:0] {
        PAC_REG_CTRL,
        PAC_REG_CNT_LO,
        PAC_REG_CNT_HI,
        PAC_REG_STAT,
        PAC_REG_MASK,
        PAC_REG_NONE
    } pac_sel_type;

endpackage
`default_nettype wire

/* hdl/pac_pin_sync.sv */
// Two-stage synchroniser and rising-edge finder for the external count pin
`timescale 1ns/100ps
`default_nettype none
module pac_pin_sync
    import pac_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic clkEn,
    input  wire logic pinIn,
    output logic      riseFast,
    output logic      riseSlow
);

    logic stage1_reg, stage1_next;
    logic stage2_reg, stage2_next;
    logic stage3_reg, stage3_next;
    logic riseDly_reg, riseDly_next;

    always_comb begin
        stage1_next  = clkEn ? pinIn : stage1_reg;
        stage2_next  = clkEn ? stage1_reg : stage2_reg;
        stage3_next  = clkEn ? stage2_reg : stage3_reg;
        riseDly_next = clkEn ? (stage2_reg & ~stage3_reg) : riseDly_reg;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg  <= 1'b0;
            stage2_reg  <= 1'b0;
            stage3_reg  <= 1'b0;
            riseDly_reg <= 1'b0;
        end else begin
            stage1_reg  <= stage1_next;
            stage2_reg  <= stage2_next;
            stage3_reg  <= stage3_next;
            riseDly_reg <= riseDly_next;
        end
    end

    // Direct edge for bypass mode, one extra resync stage otherwise
    assign riseFast = stage2_reg & ~stage3_reg; // RULE5
    assign riseSlow = riseDly_reg;

endmodule
`default_nettype wire

/* hdl/pac_prescaler.sv */
// Prescale counter dividing count ticks by one, two, four or eight
`timescale 1ns/100ps
`default_nettype none
module pac_prescaler
    import pac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clkEn,
    input  wire logic        tickIn,
    input  wire logic        clear,
    input  wire pac_div_type divSel,
    output logic             tickOut
);

    logic [PAC_PSC_W-1:0] psc_reg, psc_next;
    logic [PAC_PSC_W-1:0] divMask;

    always_comb begin
        case (divSel) // RULE2
            PAC_DIV1: divMask = 3'h0;
            PAC_DIV2: divMask = 3'h1;
            PAC_DIV4: divMask = 3'h3;
            default:  divMask = 3'h7;
        endcase
        tickOut  = tickIn & ((psc_reg & divMask) == divMask); // RULE1
        psc_next = psc_reg;
        if (clkEn) begin
            if (clear) begin
                psc_next = PAC_PSC_RESET; // RULE4
            end else if (tickIn) begin
                psc_next = psc_reg + 3'h1;
            end
        end
    end

    // No bus path reaches this count
    always_ff @(posedge clk or negedge arst_n) begin // RULE3
        if (!arst_n) begin
            psc_reg <= PAC_PSC_RESET;
        end else begin
            psc_reg <= psc_next;
        end
    end

endmodule
`default_nettype wire

/* hdl/pac_counter16.sv */
// Prescaled 16-bit counter with Wishbone register slave and overflow interrupt
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pac_counter16
    import pac_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              clkEn,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              extCountClk,
    input  wire logic              sleepMode,
    output logic                   irq
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
        $error("ADDR_W must lie between 5 and 8");
    end
    // Prescale constants are written for three bits
    if (PAC_PSC_W != 3) begin : g_bad_psc
        $error("PAC_PSC_W must be three for ratios up to eight");
    end
    // Control fields must stay inside the one written byte lane
    if (PAC_PSC_LSB + 2 > 8 || PAC_BIT_EXTSEL > 7) begin : g_bad_ctrl
        $error("Control fields do not fit the low byte");
    end
    // Reset image is cut to the control struct width
    if ($bits(pac_ctrl_type) > $bits(PAC_CTRL_RESET)) begin : g_bad_rst
        $error("Control struct wider than its reset value");
    end
    // Highest register offset must be reachable
    if (int'(PAC_OFS_MASK) >= (1 << ADDR_W)) begin : g_bad_map
        $error("ADDR_W too narrow for the register map");
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic pac_sel_type decodeAddr(input logic [ADDR_W-1:0] adr);
        logic [7:0] ofs;
        ofs = 8'(adr);
        if (ofs == PAC_OFS_CTRL) begin
            decodeAddr = PAC_REG_CTRL;
        end else if (ofs == PAC_OFS_CNT_LO) begin
            decodeAddr = PAC_REG_CNT_LO;
        end else if (ofs == PAC_OFS_CNT_HI) begin
            decodeAddr = PAC_REG_CNT_HI;
        end else if (ofs == PAC_OFS_STAT) begin
            decodeAddr = PAC_REG_STAT;
        end else if (ofs == PAC_OFS_MASK) begin
            decodeAddr = PAC_REG_MASK;
        end else begin
            decodeAddr = PAC_REG_NONE;
        end
    endfunction

    // Lane-qualified strobe for one decoded register
    function automatic logic writeHits(
        input logic        lane,
        input pac_sel_type sel,
        input pac_sel_type want
    );
        writeHits = lane && (sel == want);
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    pac_ctrl_type  ctrl_reg,  ctrl_next;
    pac_count_type count_reg, count_next;
    logic          ovfFlag_reg, ovfFlag_next;
    logic          ovfMask_reg, ovfMask_next;
    logic          ack_reg,   ack_next;
    logic [31:0]   rdData_reg, rdData_next;
    logic          irq_reg,   irq_next;

    logic          extRiseFast;
    logic          extRiseSlow;
    logic          rawTick;
    logic          pscTick;
    logic          busReq;
    logic          busWrite;
    logic          laneWrite;
    logic          countWrite;
    logic          wrapEvent;
    pac_sel_type   regSel;
    logic [15:0]   countNow;
    logic [15:0]   countInc;
    logic          wrCtrl;
    logic          wrCntLo;
    logic          wrCntHi;
    logic          wrStat;
    logic          wrMask;

    // ************************************************************
    // External pin capture
    // ************************************************************
    pac_pin_sync u_pin_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .clkEn    (clkEn),
        .pinIn    (extCountClk),
        .riseFast (extRiseFast),
        .riseSlow (extRiseSlow)
    );

    // ************************************************************
    // Count tick selection
    // ************************************************************
    // Internal clock and synchronous mode stop in sleep, like the
    // core phase clocks they follow; only bypass with the pin runs on.
    always_comb begin
        rawTick = 1'b0;
        if (ctrl_reg.on) begin
            if (ctrl_reg.extClkSel) begin
                if (ctrl_reg.syncBypass) begin
                    // Edge taken one stage early: a mode change may drop
                    // or repeat the edge already in the resync stage.
                    rawTick = extRiseFast; // RULE5 RULE6 RULE8 RULE9
                end else begin
                    rawTick = extRiseSlow & ~sleepMode;
                end
            end else begin
                rawTick = ~sleepMode;
            end
        end
    end

    pac_prescaler u_prescaler (
        .clk     (clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .tickIn  (rawTick),
        .clear   (countWrite),
        .divSel  (ctrl_reg.prescaleSel),
        .tickOut (pscTick)
    );

    // ************************************************************
    // Bus decode
    // ************************************************************
    // Write lands on the edge where ack is already high, i.e. the edge
    // at which the master samples it.
    assign busReq     = wb_cyc_i & wb_stb_i;
    assign busWrite   = busReq & wb_we_i & ack_reg;
    assign laneWrite  = busWrite & wb_sel_i[0];
    assign regSel     = decodeAddr(wb_adr_i);
    assign countWrite = wrCntLo | wrCntHi;
    assign countNow   = {count_reg.countHigh, count_reg.countLow};
    assign countInc   = countNow + 16'h0001;
    assign wrapEvent  = pscTick & (countNow == 16'hffff);

    // ************************************************************
    // Write strobes
    // ************************************************************
    // Decoded once so every register sees the same landing edge
    assign wrCtrl     = writeHits(laneWrite, regSel, PAC_REG_CTRL);
    assign wrCntLo    = writeHits(laneWrite, regSel, PAC_REG_CNT_LO);
    assign wrCntHi    = writeHits(laneWrite, regSel, PAC_REG_CNT_HI);
    assign wrStat     = writeHits(laneWrite, regSel, PAC_REG_STAT);
    assign wrMask     = writeHits(laneWrite, regSel, PAC_REG_MASK);

    // ************************************************************
    // Counter and control registers
    // ************************************************************
    always_comb begin
        ctrl_next  = ctrl_reg;
        count_next = count_reg;
        if (clkEn) begin
            if (pscTick) begin
                count_next = pac_count_type'(countInc);
            end
            // Byte written by software replaces its half; the other half may
            // still take the increment in the same cycle, hence an odd pair.
            if (wrCntLo) begin
                count_next.countLow = wb_dat_i[7:0]; // RULE13 RULE12
            end
            if (wrCntHi) begin
                count_next.countHigh = wb_dat_i[7:0]; // RULE13
            end
            if (wrCtrl) begin
                ctrl_next.on          = wb_dat_i[PAC_BIT_ON];
                ctrl_next.syncBypass  = wb_dat_i[PAC_BIT_BYPASS];
                ctrl_next.extClkSel   = wb_dat_i[PAC_BIT_EXTSEL];
                ctrl_next.prescaleSel = pac_div_type'(wb_dat_i[PAC_PSC_LSB +: 2]);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg  <= pac_ctrl_type'(PAC_CTRL_RESET[4:0]);
            count_reg <= '{countHigh: PAC_COUNT_RESET, countLow: PAC_COUNT_RESET};
        end else begin
            ctrl_reg  <= ctrl_next;
            count_reg <= count_next;
        end
    end

    // ************************************************************
    // Overflow flag, mask and interrupt
    // ************************************************************
    always_comb begin
        ovfFlag_next = ovfFlag_reg;
        ovfMask_next = ovfMask_reg;
        irq_next     = irq_reg;
        if (clkEn) begin
            if (wrMask) begin
                ovfMask_next = wb_dat_i[PAC_BIT_OVF];
            end
            if (wrStat && wb_dat_i[PAC_BIT_OVF]) begin
                ovfFlag_next = 1'b0;
            end
            // Set after clear so a wrap in the clearing cycle survives
            if (wrapEvent) begin
                ovfFlag_next = 1'b1; // RULE14
            end
            // Level stays usable as a wake request while asleep
            irq_next = ovfFlag_next & ovfMask_next; // RULE7
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovfFlag_reg <= PAC_FLAG_RESET;
            ovfMask_reg <= PAC_MASK_RESET;
            irq_reg     <= 1'b0;
        end else begin
            ovfFlag_reg <= ovfFlag_next;
            ovfMask_reg <= ovfMask_next;
            irq_reg     <= irq_next;
        end
    end

    // ************************************************************
    // Wishbone answer
    // ************************************************************
    // Read word for a decoded register; unmapped reads return zero
    function automatic logic [31:0] readWord(
        input pac_sel_type   sel,
        input pac_ctrl_type  ctrl,
        input pac_count_type count,
        input logic          flag,
        input logic          mask
    );
        logic [31:0] word;
        word = 32'h0000_0000;
        if (sel == PAC_REG_CTRL) begin
            word[PAC_BIT_ON]       = ctrl.on;
            word[PAC_BIT_BYPASS]   = ctrl.syncBypass;
            word[PAC_BIT_EXTSEL]   = ctrl.extClkSel;
            word[PAC_PSC_LSB +: 2] = ctrl.prescaleSel;
        end else if (sel == PAC_REG_CNT_LO) begin
            word[7:0] = count.countLow; // RULE10 RULE11
        end else if (sel == PAC_REG_CNT_HI) begin
            word[7:0] = count.countHigh; // RULE10
        end else if (sel == PAC_REG_STAT) begin
            word[PAC_BIT_OVF] = flag;
        end else if (sel == PAC_REG_MASK) begin
            word[PAC_BIT_OVF] = mask;
        end
        readWord = word;
    endfunction

    // Read data is registered from the settled count, so a byte never
    // mixes with a pin edge in flight. Two-byte reads are not coherent.
    always_comb begin
        ack_next    = ack_reg;
        rdData_next = rdData_reg;
        if (clkEn) begin
            ack_next    = busReq & ~ack_reg;
            rdData_next = 32'h0000_0000;
            if (busReq && !ack_reg && !wb_we_i) begin
                rdData_next = readWord(regSel, ctrl_reg, count_reg, ovfFlag_reg, ovfMask_reg);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg    <= 1'b0;
            rdData_reg <= 32'h0000_0000;
        end else begin
            ack_reg    <= ack_next;
            rdData_reg <= rdData_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdData_reg;
    assign irq      = irq_reg;

endmodule
`default_nettype wire

/* bench/pac_ext_source.sv */
// Behavioural model of the external count clock source
`timescale 1ns/100ps
`default_nettype none
module pac_ext_source
(
    input  wire logic clk,
    output logic      extCountClk
);
    // ************************************************************
    // Pulse bursts
    // ************************************************************
    initial extCountClk = 1'h0;

    // Pin rests low between bursts; hold sets prompt or slow edges
    task automatic pulses(input int n, input int hold);
        repeat (n) begin
            @(posedge clk);
            extCountClk <= 1'h1;
            repeat (hold) @(posedge clk);
            extCountClk <= 1'h0;
            repeat (hold) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

/* bench/pac_counter16_assertions.sv */
// Concurrent checks on the counter's bus and interrupt ports
`timescale 1ns/100ps
`default_nettype none
module pac_counter16_assertions
    import pac_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              clkEn,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              extCountClk,
    input wire logic              sleepMode,
    input wire logic              irq
);
    // ************************************************************
    // Bus and interrupt properties
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence reqTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
    endsequence
    sequence oneAck;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence rdAt(a);
        reqTaken ##0 (!wb_we_i && wb_adr_i == a);
    endsequence

    ack_follows_a: assert property (reqTaken |=> oneAck)
        else $error("taken request not answered by one ack");
    ack_single_a: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without strobe");
    ack_quiet_a: assert property (!wb_cyc_i [*2] |-> !wb_ack_o)
        else $error("ack on idle bus");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    unmapped_zero_a: assert property (reqTaken ##0 (!wb_we_i &&
        wb_adr_i > ADDR_W'(PAC_OFS_MASK)) |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    irq_hold_a: assert property (irq && clkEn && !wb_cyc_i && !$past(wb_cyc_i) |=> irq)
        else $error("interrupt dropped without bus write");
    stat_irq_a: assert property (irq ##0 rdAt(ADDR_W'(PAC_OFS_STAT))
        |=> wb_dat_o[PAC_BIT_OVF])
        else $error("status flag clear while interrupt high");
endmodule
bind pac_counter16 pac_counter16_assertions #(.ADDR_W(ADDR_W)) chk_u (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .extCountClk(extCountClk), .sleepMode(sleepMode),
    .irq(irq));
`default_nettype wire

/* bench/test_pac_counter16.sv */
// Self-checking bench for the prescaled 16-bit counter
`timescale 1ns/100ps
`default_nettype none
module test_pac_counter16
    import pac_pkg::*;
;
    logic        clk;
    logic        arst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] datI;
    logic [31:0] datO;
    logic        ack;
    logic        pin;
    logic        sleepMode;
    logic        irq;
    logic        clkEn;
    logic [31:0] q;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [7:0]  offs[6] = '{PAC_OFS_CTRL, PAC_OFS_CNT_LO, PAC_OFS_CNT_HI,
                             PAC_OFS_STAT, PAC_OFS_MASK, 8'h14};

    pac_counter16 dut_u (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .extCountClk(pin),
        .sleepMode(sleepMode), .irq(irq));
    pac_ext_source src_u (.clk(clk), .extCountClk(pin));

    // ************************************************************
    // Clock, timeout and bus tasks
    // ************************************************************
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until ack is seen, then idle for one cycle
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        datI <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'h1);
        q = datO;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'h1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'h0, 8'h0);
        chk(q, e);
    endtask

    // Counter is stopped again before any count write follows
    task automatic run(input logic [7:0] c, input int n);
        wr(PAC_OFS_CTRL, c);
        src_u.pulses(n, 3);
        repeat (8) @(posedge clk);
        wr(PAC_OFS_CTRL, 8'h00);
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        arst_n = 1'h0;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 8'h0;
        datI = 32'h0;
        sleepMode = 1'h0;
        clkEn = 1'h1;
        repeat (5) @(posedge clk);
        arst_n <= 1'h1;
        foreach (offs[i]) rd(offs[i], 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(PAC_OFS_CNT_LO, 8'h0);
            wr(PAC_OFS_CNT_HI, 8'h0);
            run(8'h05 | 8'(i << 4), 8);
            rd(PAC_OFS_CNT_LO, 32'(8 >> i));
        end
        run(8'h35, 5);
        wr(PAC_OFS_CNT_LO, 8'h0);
        run(8'h35, 7);
        rd(PAC_OFS_CNT_LO, 32'h0);
        run(8'h35, 1);
        rd(PAC_OFS_CNT_LO, 32'h1);
        sleepMode <= 1'h1;
        run(8'h05, 3);
        rd(PAC_OFS_CNT_LO, 32'h1);
        wr(PAC_OFS_CNT_LO, 8'hff);
        wr(PAC_OFS_CNT_HI, 8'hff);
        wr(PAC_OFS_MASK, 8'h1);
        run(8'h07, 1);
        chk({31'h0, irq}, 32'h1);
        sleepMode <= 1'h0;
        rd(PAC_OFS_CNT_LO, 32'h0);
        rd(PAC_OFS_CNT_HI, 32'h0);
        rd(PAC_OFS_STAT, 32'h1);
        wr(PAC_OFS_MASK, 8'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(PAC_OFS_MASK, 8'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(PAC_OFS_STAT, 8'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(PAC_OFS_STAT, 32'h0);
        // Internal clock at /8: thirteen ticks give one advance
        wr(PAC_OFS_CNT_LO, 8'h0);
        wr(PAC_OFS_CTRL, 8'h31);
        repeat (10) @(posedge clk);
        wr(PAC_OFS_CTRL, 8'h00);
        rd(PAC_OFS_CNT_LO, 32'h1);
        // Low clock enable freezes the pin stages: no edge is counted
        wr(PAC_OFS_CTRL, 8'h05);
        clkEn <= 1'h0;
        src_u.pulses(2, 3);
        clkEn <= 1'h1;
        wr(PAC_OFS_CTRL, 8'h00);
        rd(PAC_OFS_CNT_LO, 32'h1);
        // Mode switches in mid-stream may drop or add one edge each
        wr(PAC_OFS_CNT_LO, 8'h0);
        wr(PAC_OFS_CTRL, 8'h05);
        src_u.pulses(3, 3);
        wr(PAC_OFS_CTRL, 8'h07);
        src_u.pulses(3, 3);
        xfer(PAC_OFS_CNT_LO, 1'h0, 8'h0);
        chk(32'(q >= 32'h5 && q <= 32'h6), 32'h1);
        run(8'h05, 3);
        xfer(PAC_OFS_CNT_LO, 1'h0, 8'h0);
        chk(32'(q >= 32'h8 && q <= 32'ha), 32'h1);
        end_sim();
    end
endmodule
`default_nettype wire
